// File: common/pcf_pkg.sv
// constants for the ptp capture filter and lock block
package pcf_pkg;

	// register word addresses (byte offsets, one aligned word each)
	localparam logic [7:0] PCF_OFS_CFG      = 8'h00;
	localparam logic [7:0] PCF_OFS_AUX_HI   = 8'h04;
	localparam logic [7:0] PCF_OFS_AUX_LO   = 8'h08;
	localparam logic [7:0] PCF_OFS_STS      = 8'h0C;
	localparam logic [7:0] PCF_OFS_RX_CLK   = 8'h10;
	localparam logic [7:0] PCF_OFS_RX_SID   = 8'h14;
	localparam logic [7:0] PCF_OFS_RX_SEQ   = 8'h18;
	localparam logic [7:0] PCF_OFS_TX_CLK   = 8'h1C;
	localparam logic [7:0] PCF_OFS_TX_SID   = 8'h20;
	localparam logic [7:0] PCF_OFS_TX_SEQ   = 8'h24;
	localparam logic [7:0] PCF_OFS_P9_CLK   = 8'h28;
	localparam logic [7:0] PCF_OFS_P8_CLK   = 8'h2C;

	// config register fields
	localparam int PCF_B_ALT1    = 13;
	localparam int PCF_B_ALT2    = 12;
	localparam int PCF_B_ALT3    = 11;
	localparam int PCF_B_USER    = 10;
	localparam int PCF_B_LOCK_RX = 9;
	localparam int PCF_B_LOCK_TX = 8;
	localparam int PCF_B_LOCK_P9 = 6;
	localparam int PCF_B_LOCK_P8 = 5;
	localparam int PCF_B_MODE_HI = 4;
	localparam int PCF_B_MODE_LO = 3;
	localparam logic [31:0] PCF_CFG_RST  = 32'h0000_0360;
	localparam logic [31:0] PCF_CFG_MASK = 32'h0000_3F78;

	// status register bits, write one to clear
	localparam int PCF_S_RX  = 0;
	localparam int PCF_S_TX  = 1;
	localparam int PCF_S_P9  = 2;
	localparam int PCF_S_P8  = 3;
	localparam int PCF_STS_W = 4;
	localparam logic [PCF_STS_W-1:0] PCF_STS_RST = 4'h0;

	// aux address high part width (upper 16 of the 48 bits)
	localparam int PCF_AUX_HI_W = 16;

	// fixed ptp destination addresses
	localparam logic [47:0] PCF_ADDR_PRI  = 48'h0100_5E00_0181;
	localparam logic [47:0] PCF_ADDR_ALT1 = 48'h0100_5E00_0182;
	localparam logic [47:0] PCF_ADDR_ALT2 = 48'h0100_5E00_0183;
	localparam logic [47:0] PCF_ADDR_ALT3 = 48'h0100_5E00_0184;

	// compare event output modes
	localparam logic [1:0] PCF_MODE_PULSE  = 2'h0;
	localparam logic [1:0] PCF_MODE_TOGGLE = 2'h1;
	localparam logic [1:0] PCF_MODE_TIMER  = 2'h2;

	// pulse timing
	localparam int PCF_CLK_PS    = 5000;
	localparam int PCF_PULSE_NS  = 100;
	localparam int PCF_PULSE_CYC =
		(PCF_PULSE_NS * 1000 + PCF_CLK_PS - 1) / PCF_CLK_PS;
	localparam int PCF_PCNT_W    = 8;

endpackage : pcf_pkg

// File: design/pcf_event_out.sv
// compare event output shaper for general purpose pin 9
`timescale 1ns/1ps
module pcf_event_out
	import pcf_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	// control
	input  wire logic [1:0] mode_in,
	input  wire logic       cmp_event_in,
	input  wire logic       timer_irq_sts_in,
	// pin drive
	output logic            evt_out
);

	typedef struct packed {
		logic [PCF_PCNT_W-1:0] cnt;
		logic                  tog;
		logic                  out;
	} pcf_evt_state_t;

	pcf_evt_state_t st_r;
	pcf_evt_state_t st_nxt;

	// mode decides how the compare event shows on the pin
	always_comb begin
		st_nxt = st_r;
		if (cmp_event_in) begin
			st_nxt.tog = ~st_r.tog;
		end
		if (cmp_event_in) begin
			st_nxt.cnt = PCF_PCNT_W'(PCF_PULSE_CYC);
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		case (mode_in)
			PCF_MODE_PULSE:  st_nxt.out = (st_nxt.cnt != '0);
			PCF_MODE_TOGGLE: st_nxt.out = st_nxt.tog;
			PCF_MODE_TIMER:  st_nxt.out = timer_irq_sts_in;
			default:         st_nxt.out = 1'b0; // reserved: held low
		endcase
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign evt_out = st_r.out;

endmodule : pcf_event_out

// File: design/pcf_capture_lock.sv
// ptp destination filter, capture locks and pin 9 event mode
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - alt enable 1 at bit 13 matches 01:00:5E:00:01:82; reset 0
// - alt enable 2 at bit 12 matches 01:00:5E:00:01:83; reset 0
// - alt enable 3 at bit 11 matches 01:00:5E:00:01:84; reset 0
// - user enable at bit 10 matches the auxiliary address; reset 0
// - rx lock at bit 9 keeps rx capture while rx flag pending; reset 1
// - tx lock at bit 8 keeps tx capture while tx flag pending; reset 1
// - frames from fabric are receive, toward fabric are transmit
// - pin 9 lock at bit 6 keeps pin 9 capture while flag set; reset 1
// - pin 8 lock at bit 5 keeps pin 8 capture while flag set; reset 1
// - bits 4:3 pick pin 9 compare event output; reset 00
// - 00 pulse 100ns, 01 toggle, 10 timer flag, 11 reserved
// - writing one clears a capture flag and so releases its lock
module pcf_capture_lock
	import pcf_pkg::*;
#(
	parameter int CLK_W = 32,
	parameter int SID_W = 32,
	parameter int SEQ_W = 16
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	// register port
	input  wire logic [7:0]       reg_addr_in,
	input  wire logic [31:0]      reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output logic      [31:0]      reg_rdata_out,
	// host port frame events
	input  wire logic             frm_valid_in,
	input  wire logic             frm_from_fabric_in,
	input  wire logic [47:0]      frm_dest_addr_in,
	input  wire logic             frm_pri_en_in,
	input  wire logic             frm_capture_in,
	input  wire logic [SID_W-1:0] frm_source_identity_in,
	input  wire logic [SEQ_W-1:0] frm_seq_in,
	// time base and compare
	input  wire logic [CLK_W-1:0] ptp_clock_in,
	input  wire logic             cmp_event_in,
	input  wire logic             timer_irq_sts_in,
	// general purpose pins
	input  wire logic             pin8_in,
	input  wire logic             pin9_in,
	output logic                  pin9_evt_out,
	// status
	output logic                  host_ptp_match_out,
	output logic [PCF_STS_W-1:0]  capture_irq_sts_out
);

	typedef struct packed {
		logic [31:0]             cfg;
		logic [PCF_AUX_HI_W-1:0] aux_hi;
		logic [31:0]             aux_lo;
		logic [PCF_STS_W-1:0]    sts;
		logic [CLK_W-1:0]        rx_clk;
		logic [SID_W-1:0]        rx_sid;
		logic [SEQ_W-1:0]        rx_seq;
		logic [CLK_W-1:0]        tx_clk;
		logic [SID_W-1:0]        tx_sid;
		logic [SEQ_W-1:0]        tx_seq;
		logic [CLK_W-1:0]        p9_clk;
		logic [CLK_W-1:0]        p8_clk;
		logic                    p9_s1;
		logic                    p9_s2;
		logic                    p9_d;
		logic                    p8_s1;
		logic                    p8_s2;
		logic                    p8_d;
		logic                    match;
		logic [31:0]             rdata;
	} pcf_state_t;

	pcf_state_t st_r;
	pcf_state_t st_nxt;

	logic [47:0]          aux_addr;
	logic                 addr_hit;
	logic                 is_rx;
	logic                 is_tx;
	logic                 p9_edge;
	logic                 p8_edge;
	logic                 cap_rx;
	logic                 cap_tx;
	logic                 cap_p9;
	logic                 cap_p8;
	logic [PCF_STS_W-1:0] sts_set;
	logic [PCF_STS_W-1:0] sts_clr;
	logic                 wr_cfg;
	logic                 wr_sts;

	assign aux_addr = {st_r.aux_hi, st_r.aux_lo};

	// destination address filter for the host side port
	always_comb begin
		addr_hit = frm_pri_en_in && (frm_dest_addr_in == PCF_ADDR_PRI);
		if (st_r.cfg[PCF_B_ALT1] && frm_dest_addr_in == PCF_ADDR_ALT1) begin
			addr_hit = 1'b1;
		end
		if (st_r.cfg[PCF_B_ALT2] && frm_dest_addr_in == PCF_ADDR_ALT2) begin
			addr_hit = 1'b1;
		end
		if (st_r.cfg[PCF_B_ALT3] && frm_dest_addr_in == PCF_ADDR_ALT3) begin
			addr_hit = 1'b1;
		end
		if (st_r.cfg[PCF_B_USER] && frm_dest_addr_in == aux_addr) begin
			addr_hit = 1'b1;
		end
	end

	// direction seen from the host: out of the fabric is receive
	assign is_rx = frm_from_fabric_in;
	assign is_tx = ~frm_from_fabric_in;

	// edge detect reads only the second sync stage and its delay
	assign p9_edge = st_r.p9_s2 & ~st_r.p9_d;
	assign p8_edge = st_r.p8_s2 & ~st_r.p8_d;

	// captures allowed unless locked with a pending flag
	always_comb begin
		cap_rx = frm_valid_in && frm_capture_in && addr_hit && is_rx
			&& !(st_r.cfg[PCF_B_LOCK_RX] && st_r.sts[PCF_S_RX]);
		cap_tx = frm_valid_in && frm_capture_in && addr_hit && is_tx
			&& !(st_r.cfg[PCF_B_LOCK_TX] && st_r.sts[PCF_S_TX]);
		cap_p9 = p9_edge
			&& !(st_r.cfg[PCF_B_LOCK_P9] && st_r.sts[PCF_S_P9]);
		cap_p8 = p8_edge
			&& !(st_r.cfg[PCF_B_LOCK_P8] && st_r.sts[PCF_S_P8]);
	end

	// flag set terms; a locked capture still reasserts its flag
	always_comb begin
		sts_set = '0;
		sts_set[PCF_S_RX] = frm_valid_in && frm_capture_in && addr_hit
			&& is_rx;
		sts_set[PCF_S_TX] = frm_valid_in && frm_capture_in && addr_hit
			&& is_tx;
		sts_set[PCF_S_P9] = p9_edge;
		sts_set[PCF_S_P8] = p8_edge;
	end

	// register write decode
	assign wr_cfg  = reg_wr_in && (reg_addr_in == PCF_OFS_CFG);
	assign wr_sts  = reg_wr_in && (reg_addr_in == PCF_OFS_STS);
	assign sts_clr = wr_sts ? reg_wdata_in[PCF_STS_W-1:0] : '0;

	// next state
	always_comb begin
		st_nxt = st_r;
		// pin synchronisers
		st_nxt.p9_s1 = pin9_in;
		st_nxt.p9_s2 = st_r.p9_s1;
		st_nxt.p9_d  = st_r.p9_s2;
		st_nxt.p8_s1 = pin8_in;
		st_nxt.p8_s2 = st_r.p8_s1;
		st_nxt.p8_d  = st_r.p8_s2;
		st_nxt.match = frm_valid_in && addr_hit;
		// writable config bits only; bit 7 and others stay zero
		if (wr_cfg) begin
			st_nxt.cfg = reg_wdata_in & PCF_CFG_MASK;
		end
		if (reg_wr_in && reg_addr_in == PCF_OFS_AUX_HI) begin
			st_nxt.aux_hi = reg_wdata_in[PCF_AUX_HI_W-1:0];
		end
		if (reg_wr_in && reg_addr_in == PCF_OFS_AUX_LO) begin
			st_nxt.aux_lo = reg_wdata_in;
		end
		// write one clears, a same-cycle event wins
		st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;
		if (cap_rx) begin
			st_nxt.rx_clk = ptp_clock_in;
			st_nxt.rx_sid = frm_source_identity_in;
			st_nxt.rx_seq = frm_seq_in;
		end
		if (cap_tx) begin
			st_nxt.tx_clk = ptp_clock_in;
			st_nxt.tx_sid = frm_source_identity_in;
			st_nxt.tx_seq = frm_seq_in;
		end
		if (cap_p9) begin
			st_nxt.p9_clk = ptp_clock_in;
		end
		if (cap_p8) begin
			st_nxt.p8_clk = ptp_clock_in;
		end
		// read data stands one cycle after the strobe only
		st_nxt.rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				PCF_OFS_CFG:    st_nxt.rdata = st_r.cfg;
				PCF_OFS_AUX_HI: st_nxt.rdata = 32'(st_r.aux_hi);
				PCF_OFS_AUX_LO: st_nxt.rdata = st_r.aux_lo;
				PCF_OFS_STS:    st_nxt.rdata = 32'(st_r.sts);
				PCF_OFS_RX_CLK: st_nxt.rdata = 32'(st_r.rx_clk);
				PCF_OFS_RX_SID: st_nxt.rdata = 32'(st_r.rx_sid);
				PCF_OFS_RX_SEQ: st_nxt.rdata = 32'(st_r.rx_seq);
				PCF_OFS_TX_CLK: st_nxt.rdata = 32'(st_r.tx_clk);
				PCF_OFS_TX_SID: st_nxt.rdata = 32'(st_r.tx_sid);
				PCF_OFS_TX_SEQ: st_nxt.rdata = 32'(st_r.tx_seq);
				PCF_OFS_P9_CLK: st_nxt.rdata = 32'(st_r.p9_clk);
				PCF_OFS_P8_CLK: st_nxt.rdata = 32'(st_r.p8_clk);
				default:        st_nxt.rdata = '0; // unmapped reads zero
			endcase
		end
	end

	// state register; locks come up set
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			st_r     <= '0;
			st_r.cfg <= PCF_CFG_RST;
			st_r.sts <= PCF_STS_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pin 9 compare event output
	pcf_event_out u_evt (
		.mclk_in          (mclk_in),
		.sys_rst_in       (sys_rst_in),
		.mode_in          (st_r.cfg[PCF_B_MODE_HI:PCF_B_MODE_LO]),
		.cmp_event_in     (cmp_event_in),
		.timer_irq_sts_in (timer_irq_sts_in),
		.evt_out          (pin9_evt_out)
	);

	assign reg_rdata_out       = st_r.rdata;
	assign host_ptp_match_out  = st_r.match;
	assign capture_irq_sts_out = st_r.sts;

endmodule : pcf_capture_lock

// File: tb/pcf_capture_lock_monitor.sv
// assertion checker for the capture filter and lock block
`timescale 1ns/1ps
module pcf_capture_lock_monitor
	import pcf_pkg::*;
(
	// clock and reset
	input wire logic                 mclk_in,
	input wire logic                 sys_rst_in,
	// register port
	input wire logic [7:0]           reg_addr_in,
	input wire logic [31:0]          reg_wdata_in,
	input wire logic                 reg_wr_in,
	input wire logic                 reg_rd_in,
	input wire logic [31:0]          reg_rdata_out,
	// frames and compare
	input wire logic                 frm_valid_in,
	input wire logic [47:0]          frm_dest_addr_in,
	input wire logic                 timer_irq_sts_in,
	input wire logic                 cmp_event_in,
	// outputs watched
	input wire logic                 pin9_evt_out,
	input wire logic                 host_ptp_match_out,
	input wire logic [PCF_STS_W-1:0] capture_irq_sts_out
);
	logic [31:0] cfg_r;
	logic [1:0]  mode;
	logic        cfg_wr;
	// shadow of the config word, same write timing as the block
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			cfg_r <= PCF_CFG_RST;
		else if (reg_wr_in && reg_addr_in == PCF_OFS_CFG)
			cfg_r <= reg_wdata_in & PCF_CFG_MASK;
	end
	assign mode = cfg_r[PCF_B_MODE_HI:PCF_B_MODE_LO];
	// a config write in the sampled cycle changes the mode the pin follows
	assign cfg_wr = reg_wr_in && reg_addr_in == PCF_OFS_CFG;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	AST_ALT1: assert property (
		frm_valid_in && cfg_r[13] && frm_dest_addr_in == PCF_ADDR_ALT1
		|=> host_ptp_match_out) else $error("alt address 1 missed");
	AST_ALT2: assert property (
		frm_valid_in && cfg_r[12] && frm_dest_addr_in == PCF_ADDR_ALT2
		|=> host_ptp_match_out) else $error("alt address 2 missed");
	AST_ALT3: assert property (
		frm_valid_in && cfg_r[11] && frm_dest_addr_in == PCF_ADDR_ALT3
		|=> host_ptp_match_out) else $error("alt address 3 missed");
	AST_PULSE: assert property (
		cmp_event_in && mode == PCF_MODE_PULSE && !cfg_wr
		|=> pin9_evt_out [*8])
		else $error("pulse too short");
	AST_TOGGLE: assert property (
		cmp_event_in && mode == PCF_MODE_TOGGLE && !cfg_wr
		|=> pin9_evt_out != $past(pin9_evt_out)) else $error("no toggle");
	AST_TIMER: assert property (
		mode == PCF_MODE_TIMER && !cfg_wr
		|=> pin9_evt_out == $past(timer_irq_sts_in))
		else $error("pin does not follow timer flag");
	AST_RSVD: assert property (
		mode == 2'h3 && !cfg_wr |=> !pin9_evt_out)
		else $error("reserved mode drives");
	AST_CFG_RD: assert property (
		reg_rd_in && reg_addr_in == PCF_OFS_CFG |=> reg_rdata_out == cfg_r)
		else $error("config readback wrong");
	AST_W1C: assert property (
		reg_wr_in && reg_addr_in == PCF_OFS_STS && reg_wdata_in[1:0] == 2'h3
		&& !frm_valid_in |=> capture_irq_sts_out[1:0] == 2'h0)
		else $error("status not cleared");
endmodule : pcf_capture_lock_monitor

bind pcf_capture_lock pcf_capture_lock_monitor u_mon (.mclk_in, .sys_rst_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.frm_valid_in, .frm_dest_addr_in, .timer_irq_sts_in, .cmp_event_in,
	.pin9_evt_out, .host_ptp_match_out, .capture_irq_sts_out);

// File: tb/tb_ptp_capture_filter_lock.sv
// self-checking bench for the capture filter and lock block
`timescale 1ns/1ps
module tb_ptp_capture_filter_lock import pcf_pkg::*;;
	logic        mclk_in = 1'b0, sys_rst_in = 1'b1;
	logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, frm_valid_in = 1'b0;
	logic        frm_from_fabric_in = 1'b0, cmp_event_in = 1'b0;
	logic        timer_irq_sts_in = 1'b0, pin8_in = 1'b0, pin9_in = 1'b0;
	logic [7:0]  reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000, ptp_clock_in = 32'h0000_0000;
	logic [47:0] frm_dest_addr_in = 48'h0000_0000_0000;
	logic [15:0] frm_seq_in = 16'h0000;
	logic [31:0] reg_rdata_out;
	logic        pin9_evt_out, host_ptp_match_out;
	logic [3:0]  capture_irq_sts_out;
	int          bad_count = 0, cmp_count = 0, cyc = 0;
	pcf_capture_lock dut (.mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .frm_valid_in,
		.frm_from_fabric_in, .frm_dest_addr_in, .frm_pri_en_in(1'b0),
		.frm_capture_in(1'b1), .frm_source_identity_in(32'h0000_5A5A),
		.frm_seq_in, .ptp_clock_in, .cmp_event_in,
		.timer_irq_sts_in, .pin8_in, .pin9_in, .pin9_evt_out,
		.host_ptp_match_out, .capture_irq_sts_out);
	always #2.5 mclk_in = ~mclk_in;
	// hang guard, the whole run needs well under a thousand cycles
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// every driver starts on an edge so strobes never clash in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 chk($sformatf("reg %h", a), exp, reg_rdata_out);
	endtask : rd
	task automatic fr(input logic f, input logic [47:0] d,
		input logic [31:0] c, input logic m);
		@(posedge mclk_in);
		frm_valid_in <= 1'b1;
		frm_from_fabric_in <= f;
		frm_dest_addr_in <= d;
		ptp_clock_in <= c;
		frm_seq_in <= c[15:0];
		@(posedge mclk_in);
		frm_valid_in <= 1'b0;
		#1 chk("match", {31'h0, m}, {31'h0, host_ptp_match_out});
	endtask : fr
	task automatic pin(input int k, input logic v, input logic [31:0] c);
		@(posedge mclk_in);
		ptp_clock_in <= c;
		if (k == 2)
			pin9_in <= v;
		else
			pin8_in <= v;
		repeat (5) @(posedge mclk_in);
	endtask : pin
	task automatic ev;
		@(posedge mclk_in);
		cmp_event_in <= 1'b1;
		@(posedge mclk_in);
		cmp_event_in <= 1'b0;
		#1;
	endtask : ev
	task automatic t_filter;
		for (int i = 0; i < 3; i++) begin
			wr(PCF_OFS_CFG, 32'h0000_0000);
			fr(1'b1, PCF_ADDR_ALT1 + i, 32'h0, 1'b0);
			wr(PCF_OFS_CFG, 32'h0000_2000 >> i);
			fr(1'b1, PCF_ADDR_ALT1 + i, 32'h0, 1'b1);
		end
		wr(PCF_OFS_AUX_HI, 32'h0000_A1B2);
		wr(PCF_OFS_AUX_LO, 32'hC3D4_E5F6);
		wr(PCF_OFS_CFG, 32'h0000_0400);
		fr(1'b1, 48'hA1B2_C3D4_E5F6, 32'h0, 1'b1);
		fr(1'b1, 48'hA1B2_C3D4_E5F7, 32'h0, 1'b0);
	endtask : t_filter
	task automatic t_lock;
		wr(PCF_OFS_STS, 32'h0000_000F);
		wr(PCF_OFS_CFG, 32'h0000_2300);
		fr(1'b1, PCF_ADDR_ALT1, 32'h0000_1111, 1'b1);
		fr(1'b1, PCF_ADDR_ALT1, 32'h0000_2222, 1'b1);
		rd(PCF_OFS_RX_CLK, 32'h0000_1111);
		rd(PCF_OFS_RX_SEQ, 32'h0000_1111);
		fr(1'b0, PCF_ADDR_ALT1, 32'h0000_3333, 1'b1);
		fr(1'b0, PCF_ADDR_ALT1, 32'h0000_4444, 1'b1);
		rd(PCF_OFS_TX_CLK, 32'h0000_3333);
		rd(PCF_OFS_TX_SEQ, 32'h0000_3333);
		rd(PCF_OFS_STS, 32'h0000_0003);
		chk("irq sts", 32'h3, {28'h0, capture_irq_sts_out});
		wr(PCF_OFS_STS, 32'h0000_0003);
		fr(1'b1, PCF_ADDR_ALT1, 32'h0000_5555, 1'b1);
		rd(PCF_OFS_RX_CLK, 32'h0000_5555);
		wr(PCF_OFS_CFG, 32'h0000_2000);
		fr(1'b1, PCF_ADDR_ALT1, 32'h0000_6666, 1'b1);
		rd(PCF_OFS_RX_CLK, 32'h0000_6666);
		wr(PCF_OFS_STS, 32'h0000_000F);
	endtask : t_lock
	// second edge comes while the flag from the first is still up
	task automatic t_pin(input int k, input logic [7:0] a);
		wr(PCF_OFS_CFG, 32'h0000_0060);
		pin(k, 1'b1, 32'h0000_0A0A);
		pin(k, 1'b0, 32'h0000_0B0B);
		pin(k, 1'b1, 32'h0000_0B0B);
		pin(k, 1'b0, 32'h0000_0B0B);
		rd(a, 32'h0000_0A0A);
		rd(PCF_OFS_STS, 32'h1 << k);
		wr(PCF_OFS_STS, 32'h0000_000F);
	endtask : t_pin
	task automatic t_mode;
		int n;
		logic tg;
		n = 0;
		wr(PCF_OFS_CFG, 32'h0000_0000);
		ev();
		repeat (30) begin
			n += pin9_evt_out;
			@(posedge mclk_in);
			#1;
		end
		chk("pulse cycles", 32'd20, n);
		wr(PCF_OFS_CFG, 32'h0000_0008);
		// toggle level is relative: earlier events may have left it high
		@(posedge mclk_in);
		#1 tg = pin9_evt_out;
		ev();
		chk("toggle", {31'h0, ~tg}, {31'h0, pin9_evt_out});
		ev();
		chk("toggle", {31'h0, tg}, {31'h0, pin9_evt_out});
		wr(PCF_OFS_CFG, 32'h0000_0010);
		timer_irq_sts_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 chk("timer", 32'h1, {31'h0, pin9_evt_out});
		wr(PCF_OFS_CFG, 32'h0000_0018);
		repeat (3) @(posedge mclk_in);
		#1 chk("reserved", 32'h0, {31'h0, pin9_evt_out});
	endtask : t_mode
	initial begin
		repeat (8) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rd(PCF_OFS_CFG, 32'h0000_0360);
		wr(PCF_OFS_CFG, 32'hFFFF_FFFF);
		rd(PCF_OFS_CFG, 32'h0000_3F78);
		t_filter();
		t_lock();
		t_pin(2, PCF_OFS_P9_CLK);
		t_pin(3, PCF_OFS_P8_CLK);
		t_mode();
		complete_run();
	end
endmodule : tb_ptp_capture_filter_lock
